/* logic/wdk_defs.svh */
// Constants of the keyed-clear watchdog: offsets, fields, keys and timing.
`ifndef WDK_DEFS_SVH
`define WDK_DEFS_SVH

// ************************************************************
// Register byte offsets on the APB bus.
// ************************************************************
`define WDK_OFS_MODE 8'h00
`define WDK_OFS_KEY 8'h04
`define WDK_OFS_STATUS 8'h08
`define WDK_OFS_MASK 8'h0c
`define WDK_OFS_CTRL 8'h10

// ************************************************************
// Field layout and reset values.
// ************************************************************
`define WDK_MODE_RESET 8'h67
`define WDK_MODE_FIXED 3'h3
`define WDK_MODE_STOP_BIT 4
`define WDK_KEY_VALUE 8'hac
`define WDK_KEY_READ 8'h9a
`define WDK_ST_CLEAR 0
`define WDK_ST_VIOL 1
`define WDK_ST_OVF 2
`define WDK_CTRL_OSC_STOP 0
`define WDK_CTRL_OPT 1

// ************************************************************
// Timing: system clock, low-speed oscillator and interval base.
// ************************************************************
`define WDK_CLK_PERIOD_NS 5
`define WDK_LSO_PERIOD_NS 40
`define WDK_LSO_DIV ((`WDK_LSO_PERIOD_NS) / (`WDK_CLK_PERIOD_NS))
`define WDK_OVF_BASE 10

`endif

/* logic/wdk_pkg.sv */
// Types shared by the keyed-clear watchdog modules.
`default_nettype none

package wdk_pkg;

  // Bus request as seen by the watchdog slave.
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic bit_op;
    logic [7:0] addr;
    logic [31:0] wdata;
  } wdk_req_t;

  // Answer of the watchdog slave.
  typedef struct packed {
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } wdk_rsp_t;

  // Sticky event bits.
  typedef struct packed {
    logic ovf;
    logic viol;
    logic clr;
  } wdk_evt_t;

  // Whole state of the watchdog core.
  typedef struct packed {
    logic [7:0] mode;
    logic mode_done;
    logic [17:0] count;
    wdk_evt_t status;
    wdk_evt_t mask;
    wdk_evt_t rd_snap;
    logic osc_stop;
    logic opt_fixed;
    logic opt_seen;
    logic rst_req;
    logic [31:0] rdata;
    logic slverr;
  } wdk_state_t;

  // State of the low-speed tick divider.
  typedef struct packed {
    logic [9:0] div;
    logic tick;
  } wdk_tick_state_t;

endpackage : wdk_pkg

`default_nettype wire

/* logic/wdk_lso_tick.sv */
// Low-speed oscillator model: divides the system clock into count ticks.
`timescale 1ns/10ps
`default_nettype none
`include "wdk_defs.svh"

module wdk_lso_tick
  import wdk_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic tick_o
);

  // Divider state and its next value.
  wdk_tick_state_t st;
  wdk_tick_state_t next_st;

  // ************************************************************
  // Divider: one tick every oscillator period while running.
  // ************************************************************
  // A stopped oscillator keeps its phase, so no partial period is lost.
  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (run_i)
    begin
      if (st.div == 10'((`WDK_LSO_DIV) - 1))
      begin
        next_st.div = '0;
        next_st.tick = 1'b1;
      end
      else
      begin
        next_st.div = st.div + 10'h001;
      end
    end
  end

  // Registers the divider state.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      st <= '0;
    else
      st <= next_st;
  end

  // Tick comes straight from a flip-flop.
  assign tick_o = st.tick;

endmodule // wdk_lso_tick
`default_nettype wire

/* logic/wdk_top.sv */
// Keyed-clear watchdog timer with APB register access and interrupt.
//
// Functional notes
// R01: Mode register takes byte writes only.
// R02: Software picks interval longer than flash steps.
// R03: Wrong key byte forces internal reset.
// R04: Bit access to key register forces reset.
// R05: Key register reads fixed constant, not key.
// R06: Unstoppable oscillator keeps counting through STOP.
// R07: Overflow without clear forces internal reset.
// R08: Software services watchdog via auxiliary timer wakeups.
// R09: Mode writable once; second write resets.
// R10: Software writes mode top bits as 011.
// R11: Stoppable oscillator freezes count in HALT/STOP.
// R12: Correct key clears counter, no reset.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "wdk_defs.svh"

module wdk_top
  import wdk_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic bit_access_i,
  input wire logic opt_osc_fixed_i,
  input wire logic halt_i,
  input wire logic stop_i,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] prdata_o,
  output logic irq_o,
  output logic wdt_reset_o
);

  // ************************************************************
  // Functions.
  // ************************************************************

  // Last count value before overflow for a clock select code.
  function automatic logic [17:0] wdk_last(input logic [2:0] sel);
    logic [17:0] one;
    one = 18'h00001;
    return (one << (`WDK_OVF_BASE + int'(sel))) - one;
  endfunction

  // True when the address is one of the mapped registers.
  function automatic logic wdk_mapped(input logic [7:0] a);
    return (a == `WDK_OFS_MODE) || (a == `WDK_OFS_KEY) ||
      (a == `WDK_OFS_STATUS) || (a == `WDK_OFS_MASK) ||
      (a == `WDK_OFS_CTRL);
  endfunction

  // ************************************************************
  // Declarations.
  // ************************************************************
  wdk_state_t st; // Registered state.
  wdk_state_t next_st; // Next state.
  wdk_req_t req; // Bundled bus request.
  logic tick; // Low-speed oscillator tick.
  logic osc_run; // Oscillator running.
  logic wd_stopped; // Mode selects the stopped watchdog.
  logic exempt; // Violations ignored after a stopping first write.
  logic setup; // Setup phase of an APB transfer.
  logic acc; // Access phase; zero wait, so also completion.
  logic wr; // Completed write.
  logic rd; // Completed read.
  logic key_wr; // Write to the key register.
  logic mode_wr; // Write to the mode register.
  logic good_key; // Accepted key write.
  logic bad_key; // Refused key write or bit access.
  logic bad_mode; // Refused mode write.
  logic ovf; // Counter overflow this cycle.
  logic freeze; // Low-power freeze of the counter.
  logic counting; // Counter advances on this tick.

  assign req = '{sel: psel_i, enable: penable_i, write: pwrite_i,
                 bit_op: bit_access_i, addr: paddr_i, wdata: pwdata_i};

  // ************************************************************
  // Access decode and violation detection.
  // ************************************************************
  assign setup = req.sel && !req.enable;
  assign acc = req.sel && req.enable;
  assign wr = acc && req.write;
  assign rd = acc && !req.write;
  assign key_wr = wr && (req.addr == `WDK_OFS_KEY);
  assign mode_wr = wr && (req.addr == `WDK_OFS_MODE);
  assign wd_stopped = st.mode[`WDK_MODE_STOP_BIT];
  // A first write that stopped the watchdog makes later misuse harmless.
  assign exempt = st.mode_done && wd_stopped; // [R09]
  assign good_key = key_wr && !req.bit_op &&
    (req.wdata[7:0] == `WDK_KEY_VALUE); // [R12]
  // Any other byte, or any bit operation, is a violation unless exempt.
  assign bad_key = key_wr && !good_key && !exempt; // [R03] [R04]
  // A bit operation on the mode register, or a repeat, is refused.
  assign bad_mode = mode_wr && (st.mode_done || req.bit_op) &&
    !exempt; // [R01] [R09]

  // ************************************************************
  // Counting enable.
  // ************************************************************
  // Only a stoppable oscillator freezes in HALT or STOP or on request.
  assign freeze = !st.opt_fixed &&
    (halt_i || stop_i || st.osc_stop); // [R06] [R11]
  assign osc_run = !freeze;
  assign counting = tick && !wd_stopped && !st.rst_req;
  // A key in the overflow cycle wins, so serviced software is not reset.
  assign ovf = counting && !good_key &&
    (st.count == wdk_last(st.mode[2:0])); // [R07]

  // ************************************************************
  // Oscillator tick source.
  // ************************************************************
  wdk_lso_tick u_tick (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .run_i(osc_run),
    .tick_o(tick)
  );

  // ************************************************************
  // Next-state logic.
  // ************************************************************
  // Registers, counter, sticky events and read data are all formed here.
  always_comb
  begin
    next_st = st;
    // The option level is caught once, on the first edge after release.
    if (!st.opt_seen)
    begin
      next_st.opt_seen = 1'b1;
      next_st.opt_fixed = opt_osc_fixed_i;
    end
    // Counter: cleared by key, advanced on ticks, wrapped at overflow.
    if (good_key)
      next_st.count = '0; // [R12]
    else if (counting)
      next_st.count = ovf ? '0 : st.count + 18'h00001;
    // Mode: one byte write accepted after reset.
    if (mode_wr && !st.mode_done && !req.bit_op)
    begin
      next_st.mode = req.wdata[7:0]; // [R01]
      next_st.mode_done = 1'b1; // [R09]
    end
    // Other writes.
    if (wr && (req.addr == `WDK_OFS_MASK))
      next_st.mask = req.wdata[2:0];
    if (wr && (req.addr == `WDK_OFS_CTRL))
      next_st.osc_stop = req.wdata[`WDK_CTRL_OSC_STOP];
    // Internal reset request stays until the system reset.
    if (bad_key || bad_mode || ovf)
      next_st.rst_req = 1'b1; // [R03] [R07] [R09]
    // Status read clears only the bits it returned.
    if (rd && (req.addr == `WDK_OFS_STATUS))
      next_st.status = st.status & ~st.rd_snap;
    // Events set after the clear, so a simultaneous event wins.
    if (good_key)
      next_st.status.clr = 1'b1;
    if (bad_key || bad_mode)
      next_st.status.viol = 1'b1;
    if (ovf)
      next_st.status.ovf = 1'b1;
    // Read data are latched in the setup phase.
    next_st.slverr = 1'b0;
    if (setup)
    begin
      next_st.rdata = '0;
      next_st.rd_snap = '0;
      next_st.slverr = !wdk_mapped(req.addr);
      case (req.addr)
        `WDK_OFS_MODE: next_st.rdata[7:0] = st.mode;
        `WDK_OFS_KEY: next_st.rdata[7:0] = `WDK_KEY_READ; // [R05]
        `WDK_OFS_STATUS:
        begin
          next_st.rdata[2:0] = st.status;
          next_st.rd_snap = st.status;
        end
        `WDK_OFS_MASK: next_st.rdata[2:0] = st.mask;
        `WDK_OFS_CTRL:
        begin
          next_st.rdata[`WDK_CTRL_OSC_STOP] = st.osc_stop;
          next_st.rdata[`WDK_CTRL_OPT] = st.opt_fixed;
        end
        default: next_st.rdata = '0;
      endcase
    end
    else if (acc)
    begin
      next_st.slverr = st.slverr;
    end
  end

  // ************************************************************
  // State register.
  // ************************************************************
  // Reset loads constants only; the option is caught after release.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.mode <= `WDK_MODE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ************************************************************
  // Outputs.
  // ************************************************************
  assign pready_o = acc; // Zero-wait answer in the access phase.
  assign pslverr_o = acc && st.slverr; // Unmapped address answer.
  assign prdata_o = st.rdata; // Registered read data.
  assign irq_o = |(st.status & st.mask); // Level interrupt.
  assign wdt_reset_o = st.rst_req; // Registered reset request.

  // ************************************************************
  // Assertions.
  // ************************************************************
  key_read_value_a: assert property ( // [R05]
    @(posedge mclk_i) disable iff (rst_i)
    rd && (req.addr == `WDK_OFS_KEY) |-> prdata_o[7:0] == `WDK_KEY_READ &&
      prdata_o[7:0] != `WDK_KEY_VALUE)
    else $error("key register read is not the fixed constant");

  bad_key_reset_a: assert property ( // [R03]
    @(posedge mclk_i) disable iff (rst_i)
    key_wr && !req.bit_op && req.wdata[7:0] != `WDK_KEY_VALUE && !exempt
      |=> wdt_reset_o)
    else $error("wrong key did not raise reset");

  bit_key_reset_a: assert property ( // [R04]
    @(posedge mclk_i) disable iff (rst_i)
    key_wr && req.bit_op && !exempt |=> wdt_reset_o ##1 wdt_reset_o)
    else $error("bit access to key did not raise reset");

  good_key_clear_a: assert property ( // [R12]
    @(posedge mclk_i) disable iff (rst_i)
    good_key && !wdt_reset_o && !bad_mode |=> st.count == 18'h00000 &&
      !wdt_reset_o && st.status.clr)
    else $error("correct key did not clear the counter");

  mode_once_a: assert property ( // [R09]
    @(posedge mclk_i) disable iff (rst_i)
    mode_wr && st.mode_done && !exempt |=> wdt_reset_o &&
      $stable(st.mode))
    else $error("second mode write not caught");

  mode_bit_write_a: assert property ( // [R01]
    @(posedge mclk_i) disable iff (rst_i)
    mode_wr && req.bit_op |=> $stable(st.mode) && $stable(st.mode_done))
    else $error("bit write changed the mode register");

  overflow_reset_a: assert property ( // [R07]
    @(posedge mclk_i) disable iff (rst_i)
    counting && !good_key && st.count == wdk_last(st.mode[2:0])
      |=> wdt_reset_o && st.status.ovf)
    else $error("overflow did not raise reset");

  freeze_hold_a: assert property ( // [R11]
    @(posedge mclk_i) disable iff (rst_i)
    st.opt_seen && !st.opt_fixed && (halt_i || stop_i) |=> !tick)
    else $error("oscillator ticked while frozen");

  stop_counts_a: assert property ( // [R06]
    @(posedge mclk_i) disable iff (rst_i)
    st.opt_fixed && stop_i && !wd_stopped && !wdt_reset_o
      |-> ##[1:8] tick)
    else $error("unstoppable oscillator stalled in stop");

  // A status read with no overflow in the same cycle leaves none of the bits it returned set.
  status_read_clear_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    rd && req.addr == `WDK_OFS_STATUS && !ovf |=>
      (st.status & $past(st.rd_snap)) == 3'h0)
    else $error("status read did not clear the returned bits");

  viol_flag_set_a: assert property ( // [R03]
    @(posedge mclk_i) disable iff (rst_i)
    bad_key || bad_mode |=> st.status.viol)
    else $error("violation did not set its status bit");

  reset_sticky_a: assert property ( // [R07]
    @(posedge mclk_i) disable iff (rst_i)
    wdt_reset_o |=> wdt_reset_o)
    else $error("internal reset request dropped");

  fixed_no_freeze_a: assert property ( // [R06]
    @(posedge mclk_i) disable iff (rst_i)
    st.opt_seen && st.opt_fixed |-> osc_run)
    else $error("unstoppable oscillator was frozen");

endmodule // wdk_top
`default_nettype wire

/* tb/wdk_cpu_model.sv */
// CPU core model that issues APB register accesses to the watchdog.
`timescale 1ns/10ps
`default_nettype none

module wdk_cpu_model
(
  input wire logic mclk_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  input wire logic [31:0] prdata_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic bit_access_o
);
  // ****************************************
  // Bus idle levels at time zero.
  // ****************************************
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
    bit_access_o = 1'b0;
  end

  // ****************************************
  // One whole transfer: setup, access, answer, release.
  // ****************************************
  // Only whole-byte mode writes unless bit_op asks otherwise.
  // Mode values come from the caller with top bits 011.
  task automatic xfer(input logic wr, input logic [7:0] addr,
    input logic [31:0] data, input logic bit_op,
    output logic [31:0] rdata, output logic err);
    @(posedge mclk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= addr;
    pwdata_o <= data;
    bit_access_o <= bit_op;
    @(posedge mclk_i);
    penable_o <= 1'b1;
    // The answer is sampled at the rising edge that commits the access.
    @(posedge mclk_i);
    while (pready_i !== 1'b1)
      @(posedge mclk_i);
    rdata = prdata_i;
    err = pslverr_i;
    // The request is released only after the commit edge.
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    bit_access_o <= 1'b0;
    // A released data bus shows the inverse, not the old value.
    pwdata_o <= ~data;
  endtask
endmodule // wdk_cpu_model

`default_nettype wire

/* tb/tb_top.sv */
// Self-checking testbench of the keyed-clear watchdog.
`timescale 1ns/10ps
`default_nettype none
`include "wdk_defs.svh"

module tb_top
  import wdk_pkg::*;
;
  logic mclk_i = 1'b0; // System clock.
  logic rst_i = 1'b1; // Reset, held at start.
  logic opt_fixed = 1'b0; // Power-up oscillator option.
  logic halt = 1'b0; // CPU halt state.
  logic stop = 1'b0; // CPU stop state.
  logic psel, penable, pwrite, bit_op, pready, pslverr, irq, wdt_rst;
  logic [7:0] paddr; // Bus address.
  logic [31:0] pwdata, prdata; // Bus data.
  logic [31:0] rd_v; // Last read data.
  logic err_v; // Last error response.
  int n_errors = 0; // Mismatches seen.
  int n_compared = 0; // Comparisons made.

  // Clock of 5 ns period.
  always #2.5 mclk_i = ~mclk_i;

  wdk_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .bit_access_i(bit_op),
    .opt_osc_fixed_i(opt_fixed), .halt_i(halt), .stop_i(stop),
    .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata),
    .irq_o(irq), .wdt_reset_o(wdt_rst));

  wdk_cpu_model cpu (.mclk_i(mclk_i), .pready_i(pready),
    .pslverr_i(pslverr), .prdata_i(prdata), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .bit_access_o(bit_op));

  // ****************************************
  // Shared helpers.
  // ****************************************
  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register write and read through the CPU model.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic b);
    cpu.xfer(1'b1, a, d, b, rd_v, err_v);
  endtask
  task automatic rd(input logic [7:0] a);
    cpu.xfer(1'b0, a, 32'h0, 1'b0, rd_v, err_v);
  endtask

  // Resets the block with the chosen oscillator option.
  task automatic do_reset(input logic opt);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    opt_fixed <= opt;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
  endtask

  // Lets a registered reset request land, then checks it.
  task automatic chk_rst(input logic exp);
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("wdt_reset", {31'h0, exp}, {31'h0, wdt_rst});
  endtask

  // ****************************************
  // Scenarios.
  // ****************************************
  // Good key, status, interrupt, unmapped and control reads.
  task automatic t_key();
    do_reset(1'b0);
    rd(`WDK_OFS_KEY);
    chk("key read", 32'h9a, rd_v);
    wr(`WDK_OFS_MASK, 32'h7, 1'b0);
    wr(`WDK_OFS_KEY, 32'hac, 1'b0);
    chk_rst(1'b0);
    chk("irq set", 32'h1, {31'h0, irq});
    rd(`WDK_OFS_STATUS);
    chk("status", 32'h1, rd_v);
    @(negedge mclk_i);
    chk("irq clear", 32'h0, {31'h0, irq});
    rd(`WDK_OFS_STATUS);
    chk("status again", 32'h0, rd_v);
    rd(8'h14);
    chk("unmapped err", 32'h1, {31'h0, err_v});
    chk("unmapped data", 32'h0, rd_v);
    rd(`WDK_OFS_CTRL);
    chk("ctrl opt0", 32'h0, rd_v);
  endtask

  // Each of four wrong key bytes forces the internal reset.
  task automatic t_bad_key();
    logic [7:0] bad [4];
    bad = '{8'h00, 8'had, 8'h9a, 8'hff};
    foreach (bad[i])
    begin
      do_reset(1'b0);
      wr(`WDK_OFS_KEY, {24'h0, bad[i]}, 1'b0);
      chk_rst(1'b1);
    end
  endtask

  // Single-bit access to the key register, even with the good key.
  task automatic t_bit_key();
    do_reset(1'b0);
    wr(`WDK_OFS_KEY, 32'hac, 1'b1);
    chk_rst(1'b1);
  endtask

  // Mode is written once; a second write resets.
  task automatic t_mode_once();
    do_reset(1'b0);
    wr(`WDK_OFS_MODE, 32'h63, 1'b0);
    rd(`WDK_OFS_MODE);
    chk("mode", 32'h63, rd_v);
    chk_rst(1'b0);
    wr(`WDK_OFS_MODE, 32'h63, 1'b0);
    chk_rst(1'b1);
  endtask

  // A first write that stops the watchdog exempts later faults.
  task automatic t_mode_stop();
    do_reset(1'b0);
    wr(`WDK_OFS_MODE, 32'h70, 1'b0);
    wr(`WDK_OFS_MODE, 32'h61, 1'b0);
    wr(`WDK_OFS_KEY, 32'h55, 1'b0);
    wr(`WDK_OFS_KEY, 32'hac, 1'b1);
    chk_rst(1'b0);
  endtask

  // A single-bit mode access never stores and resets.
  task automatic t_mode_bit();
    do_reset(1'b0);
    wr(`WDK_OFS_MODE, 32'h62, 1'b1);
    rd(`WDK_OFS_MODE);
    chk("mode kept", 32'h67, rd_v);
    chk_rst(1'b1);
  endtask

  // The fixed-oscillator option is captured and visible.
  task automatic t_opt();
    do_reset(1'b1);
    rd(`WDK_OFS_CTRL);
    chk("ctrl opt1", 32'h2, rd_v & 32'h2);
  endtask

  // Service inside the interval, then overflow without service.
  task automatic t_ovf();
    do_reset(1'b0);
    wr(`WDK_OFS_MODE, 32'h60, 1'b0);
    repeat (4800) @(posedge mclk_i);
    wr(`WDK_OFS_KEY, 32'hac, 1'b0);
    repeat (4800) @(posedge mclk_i);
    chk_rst(1'b0);
    repeat (4000) @(posedge mclk_i);
    chk_rst(1'b1);
    rd(`WDK_OFS_STATUS);
    chk("status ovf", 32'h4, rd_v & 32'h4);
  endtask

  // Stoppable oscillator: HALT then STOP hold the count, which resumes.
  task automatic t_freeze();
    do_reset(1'b0);
    wr(`WDK_OFS_MODE, 32'h60, 1'b0);
    repeat (4800) @(posedge mclk_i);
    halt <= 1'b1;
    repeat (4500) @(posedge mclk_i);
    halt <= 1'b0;
    stop <= 1'b1;
    repeat (4500) @(posedge mclk_i);
    chk_rst(1'b0);
    @(posedge mclk_i);
    stop <= 1'b0;
    repeat (4800) @(posedge mclk_i);
    chk_rst(1'b1);
  endtask

  // Unstoppable oscillator: STOP and a stop request leave it counting.
  task automatic t_fixed();
    do_reset(1'b1);
    wr(`WDK_OFS_MODE, 32'h60, 1'b0);
    wr(`WDK_OFS_CTRL, 32'h1, 1'b0);
    @(posedge mclk_i);
    stop <= 1'b1;
    repeat (2)
    begin
      repeat (4800) @(posedge mclk_i);
      wr(`WDK_OFS_KEY, 32'hac, 1'b0);
    end
    chk_rst(1'b0);
    repeat (9000) @(posedge mclk_i);
    chk_rst(1'b1);
    @(posedge mclk_i);
    stop <= 1'b0;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence after the start-up reset.
  initial
  begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_key();
    t_bad_key();
    t_bit_key();
    t_mode_once();
    t_mode_stop();
    t_mode_bit();
    t_opt();
    t_ovf();
    t_freeze();
    t_fixed();
    give_verdict();
  end

  // Cuts a hang short, well beyond the some 51000 cycles the tests take.
  initial
  begin
    #400000;
    n_errors++;
    give_verdict();
  end
endmodule // tb_top

`default_nettype wire
